// [hw/adrs_pkg.sv]
/*
 Constants shared by the result-ready serial port: register selects, word sizes,
 reset values and the pre-update warning time.
 Assumes a 10 MHz master clock.
*/
package adrs_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Warning interval ahead of an output update, in master clock periods
   localparam int WARN_PERIODS = 500;
   localparam int WARN_CYCLES = (WARN_PERIODS > 0) ? WARN_PERIODS : 1;
   // Register-select field codes held in comm[6:4]
   localparam logic [2:0] SEL_COMM = 3'h0;
   localparam logic [2:0] SEL_SETUP = 3'h1;
   localparam logic [2:0] SEL_CLOCK = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam int SEL_LSB = 4;
   localparam int RW_BIT = 3;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [7:0] COMM_RST = 8'h00;
   localparam logic [7:0] SETUP_RST = 8'h01;
   localparam logic [7:0] CLOCK_RST = 8'h05;
endpackage

// [hw/adrs_port.sv]
/*
 Serial port and result-ready logic of a sigma-delta converter.
 Assumes the host drives the serial clock, chip select and data in from its own
 clock domain; results and calibration completion arrive as one-cycle strobes.
*/
// Overview of operation
// [RULE_01] Result-ready goes low when a fresh result sits in the data register.
// [RULE_02] Result-ready goes high after the host reads a complete data word.
// [RULE_03] Unread result: ready high for 500 clocks before next update.
// [RULE_04] Host must not read while result-ready is high.
// [RULE_05] Result-ready goes low again once the update completes.
// [RULE_06] Result-ready also flags end of calibration.
// [RULE_07] Output shifter loads the register named by the select bits.
// [RULE_08] Input words go to setup, clock or comm per select bits.
// [RULE_09] Chip select active low; tied low gives three-wire mode.
// [RULE_10] Reset returns all control and interface state to power-on.
// [RULE_11] Serial clock may be continuous or bursty.
// [RULE_12] After reset or each access, next write targets comm register.
`timescale 1ns/1ps
module adrs_port (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   input wire logic update_req_in,
   input wire logic [15:0] result_in,
   input wire logic cal_done_in,
   output logic dout_out,
   output logic result_ready_n_out,
   output logic update_busy_out,
   output logic [7:0] setup_out,
   output logic [7:0] clock_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_WARN} adrs_wst_t;
   typedef struct packed {
      logic sclk_d;
      logic [7:0] comm;
      logic [7:0] setup;
      logic [7:0] clkreg;
      logic [15:0] data;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic [4:0] bits;
      logic [4:0] len;
      logic rd_phase;
      logic dout;
      logic ready_n;
      logic unread;
      adrs_wst_t wst;
      logic [15:0] wcnt;
      logic [15:0] pend;
   } adrs_port_t;
   adrs_port_t st_ff;
   adrs_port_t nxt_st;
   logic sclk_s;
   logic cs_n_s;
   logic din_s;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   adrs_sync #(.W(3)) u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .d_in({sclk_in, cs_n_in, din_in}),
      .rst_val_in(3'h6),
      .q_out({sclk_s, cs_n_s, din_s})
   );

   function automatic logic [4:0] word_len(input logic [2:0] sel);
      word_len = (sel == adrs_pkg::SEL_DATA) ? 5'h10 : 5'h08;
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   logic rise;
   logic fall;
   logic [2:0] sel;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_d = sclk_s;
      rise = sclk_s & ~st_ff.sclk_d & ~cs_n_s; // RULE_11
      fall = ~sclk_s & st_ff.sclk_d & ~cs_n_s;
      sel = st_ff.comm[adrs_pkg::SEL_LSB +: 3];
      // Raising chip select mid-word drops the partial word (frame sync use)
      if (cs_n_s) begin // RULE_09
         nxt_st.bits = 5'h00;
      end
      if (fall && st_ff.rd_phase) begin
         nxt_st.dout = st_ff.shift_out[15];
         nxt_st.shift_out = {st_ff.shift_out[14:0], 1'b0};
      end
      if (rise) begin
         nxt_st.bits = st_ff.bits + 5'h01;
         if (!st_ff.rd_phase) begin
            nxt_st.shift_in = {st_ff.shift_in[14:0], din_s};
         end
         if (st_ff.bits + 5'h01 == st_ff.len) begin
            nxt_st.bits = 5'h00;
            nxt_st.len = 5'h08;
            nxt_st.rd_phase = 1'b0;
            if (st_ff.rd_phase) begin
               if (sel == adrs_pkg::SEL_DATA) begin
                  nxt_st.ready_n = 1'b1; // RULE_02
                  nxt_st.unread = 1'b0;
               end
            end else if (st_ff.len == 5'h08 && st_ff.pend == 16'h0000) begin
               // Communications word just arrived
               nxt_st.comm = {st_ff.shift_in[6:0], din_s};
               nxt_st.len = word_len(st_ff.shift_in[5:3]);
               nxt_st.rd_phase = st_ff.shift_in[2];
               nxt_st.pend = 16'h0001;
               if (st_ff.shift_in[2]) begin // RULE_07
                  case (st_ff.shift_in[5:3])
                     adrs_pkg::SEL_SETUP: nxt_st.shift_out = {st_ff.setup, 8'h00};
                     adrs_pkg::SEL_CLOCK: nxt_st.shift_out = {st_ff.clkreg, 8'h00};
                     adrs_pkg::SEL_DATA: nxt_st.shift_out = st_ff.data;
                     default: nxt_st.shift_out = {st_ff.shift_in[6:0], din_s, 8'h00};
                  endcase
               end
            end else begin
               case (sel) // RULE_08
                  adrs_pkg::SEL_SETUP: nxt_st.setup = {st_ff.shift_in[6:0], din_s};
                  adrs_pkg::SEL_CLOCK: nxt_st.clkreg = {st_ff.shift_in[6:0], din_s};
                  default: nxt_st.comm = {st_ff.shift_in[6:0], din_s};
               endcase
            end
            if (st_ff.pend != 16'h0000) begin
               nxt_st.pend = 16'h0000; // RULE_12
            end
         end
      end
      // Update sequencing
      case (st_ff.wst)
         ST_IDLE: begin
            if (update_req_in) begin
               if (st_ff.unread) begin
                  nxt_st.wst = ST_WARN;
                  nxt_st.ready_n = 1'b1; // RULE_03
                  nxt_st.wcnt = 16'(adrs_pkg::WARN_CYCLES - 1);
               end else begin
                  nxt_st.data = result_in;
                  nxt_st.ready_n = 1'b0; // RULE_01
                  nxt_st.unread = 1'b1;
               end
            end
         end
         ST_WARN: begin
            if (st_ff.wcnt == 16'h0000) begin
               nxt_st.wst = ST_IDLE;
               nxt_st.data = result_in;
               nxt_st.ready_n = 1'b0; // RULE_05
               nxt_st.unread = 1'b1;
            end else begin
               nxt_st.wcnt = st_ff.wcnt - 16'h0001;
               nxt_st.ready_n = 1'b1;
            end
         end
         default: nxt_st.wst = ST_IDLE;
      endcase
      if (cal_done_in) begin
         nxt_st.ready_n = 1'b0; // RULE_06
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin // RULE_10
         st_ff <= '{sclk_d: 1'b1, comm: adrs_pkg::COMM_RST, setup: adrs_pkg::SETUP_RST,
                    clkreg: adrs_pkg::CLOCK_RST, data: 16'h0000, shift_in: 16'h0000,
                    shift_out: 16'h0000, bits: 5'h00, len: 5'h08, rd_phase: 1'b0,
                    dout: 1'b1, ready_n: 1'b1, unread: 1'b0, wst: ST_IDLE,
                    wcnt: 16'h0000, pend: 16'h0000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout_out = st_ff.dout;
   assign result_ready_n_out = st_ff.ready_n;
   assign update_busy_out = (st_ff.wst == ST_WARN);
   assign setup_out = st_ff.setup;
   assign clock_out = st_ff.clkreg;

   // ****************************************
   // Checks
   // ****************************************
   warn_high_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_03
      (st_ff.wst == ST_WARN && !cal_done_in) |-> st_ff.ready_n == 1'b1 || $past(cal_done_in))
      else $error("ready low during warning");
   // Independent count of warning cycles; a long plain delay is too costly to unroll
   logic [15:0] warn_run_ff;
   always_ff @(posedge clk_in) begin
      if (!rst_b_in || st_ff.wst != ST_WARN) begin
         warn_run_ff <= 16'h0000;
      end else begin
         warn_run_ff <= warn_run_ff + 16'h0001;
      end
   end
   warn_len_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_03
      (st_ff.wst == ST_WARN && warn_run_ff == 16'(adrs_pkg::WARN_CYCLES - 1))
      |=> st_ff.wst == ST_IDLE)
      else $error("warning interval length wrong");
   warn_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_03
      (st_ff.wst == ST_WARN && warn_run_ff != 16'(adrs_pkg::WARN_CYCLES - 1))
      |=> st_ff.wst == ST_WARN)
      else $error("warning interval ended early");
   update_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_05
      (st_ff.wst == ST_WARN && st_ff.wcnt == 16'h0000) |=> !st_ff.ready_n)
      else $error("ready not low after update");
   fresh_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_01
      (st_ff.wst == ST_IDLE && update_req_in && !st_ff.unread)
      |=> !st_ff.ready_n && st_ff.data == $past(result_in))
      else $error("fresh result not flagged");
   cal_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_06
      cal_done_in |=> !st_ff.ready_n)
      else $error("calibration end not flagged");
   read_high_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_02
      (rise && st_ff.rd_phase && sel == adrs_pkg::SEL_DATA && st_ff.bits == 5'h0f
       && !update_req_in && st_ff.wst == ST_IDLE && !cal_done_in) |=> st_ff.ready_n)
      else $error("ready not high after read");
   cs_idle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_09
      cs_n_s |=> st_ff.bits == 5'h00)
      else $error("bit count moved while deselected");
   comm_next_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE_12
      (rise && st_ff.pend != 16'h0000 && st_ff.bits + 5'h01 == st_ff.len)
      |=> st_ff.len == 5'h08 && st_ff.pend == 16'h0000)
      else $error("comm not selected after access");
   reset_a: assert property (@(posedge clk_in) // RULE_10
      !rst_b_in |=> st_ff.ready_n && st_ff.comm == adrs_pkg::COMM_RST)
      else $error("reset state wrong");
   cv_warn_c: cover property (@(posedge clk_in) st_ff.wst == ST_WARN);
   cv_read_c: cover property (@(posedge clk_in) $rose(st_ff.ready_n) && st_ff.wst == ST_IDLE);
   cv_cal_c: cover property (@(posedge clk_in) cal_done_in);
endmodule

// [hw/adrs_sync.sv]
/*
 Two flip-flop synchroniser for asynchronous pins.
 Assumes the input may change at any time relative to clk_in.
*/
`timescale 1ns/1ps
module adrs_sync #(
   parameter int W = 3
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [W-1:0] d_in,
   input wire logic [W-1:0] rst_val_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } adrs_sync_t;
   adrs_sync_t st_ff;
   adrs_sync_t nxt_st;
   always_comb begin
      nxt_st.s1 = d_in;
      nxt_st.s2 = st_ff.s1;
   end
   // Reset value is a constant in practice; tie rst_val_in to a literal
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         st_ff <= '{s1: rst_val_in, s2: rst_val_in};
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign q_out = st_ff.s2;
endmodule

// [verification/adc_data_ready_serial_port_bench.sv]
/*
 Self-checking bench for the result-ready serial port with a behavioural model.
 Assumes adrs_port, adrs_pkg and the host model adrs_host are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module adc_data_ready_serial_port_bench;
   logic clk_in = 1'b0, rst_b_in = 1'b0, update_req_in = 1'b0, cal_done_in = 1'b0;
   logic [15:0] result_in = 16'h0000;
   wire logic sclk, cs_n, din, dout_out, result_ready_n_out, update_busy_out;
   wire logic [7:0] setup_out, clock_out;
   int n_fail = 0, n_compared = 0, cycles = 0, seed = 53, k, bad;
   logic [7:0] exp_setup, exp_clock;
   logic [15:0] rd, v, w;
   // Model of the data register: at most one unread result
   logic [15:0] exp_q[$];

   initial forever #50 clk_in = ~clk_in;

   adrs_port dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .din_in(din), .update_req_in(update_req_in), .result_in(result_in),
      .cal_done_in(cal_done_in), .dout_out(dout_out),
      .result_ready_n_out(result_ready_n_out), .update_busy_out(update_busy_out),
      .setup_out(setup_out), .clock_out(clock_out));
   adrs_host host (.clk_in(clk_in), .dout_in(dout_out), .sclk_out(sclk), .cs_n_out(cs_n),
      .din_out(din));

   // ***************
   // Tasks
   // ***************
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic do_reset;
      @(negedge clk_in);
      rst_b_in = 1'b0;
      repeat (8) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (4) @(negedge clk_in);
      exp_setup = adrs_pkg::SETUP_RST;
      exp_clock = adrs_pkg::CLOCK_RST;
   endtask

   task automatic access(input logic [7:0] comm, input int n, input logic [15:0] d);
      host.xfer(8, {8'h00, comm}, $unsigned($random(seed)) % 3, rd);
      host.xfer(n, d, 0, rd);
   endtask

   task automatic push(input logic [15:0] val);
      @(negedge clk_in);
      result_in = val;
      update_req_in = 1'b1;
      @(negedge clk_in);
      update_req_in = 1'b0;
      // An unread result is overwritten by the next update
      exp_q.delete();
      exp_q.push_back(val);
   endtask

   task automatic wait_ready;
      k = 0;
      while (result_ready_n_out !== 1'b0 && k < 600) begin
         @(negedge clk_in);
         k++;
      end
   endtask

   task automatic read_data;
      logic [15:0] m;
      m = 16'hffff;
      if (exp_q.size() > 0) m = exp_q.pop_front();
      access(8'h38, 16, 16'h0000);
      `CHK(rd, m)
      `CHK(result_ready_n_out, 1'b1)
   endtask

   // ***************
   // Main sequence
   // ***************
   initial begin
      do_reset();
      `CHK({result_ready_n_out, update_busy_out, dout_out}, 3'h5)
      `CHK({setup_out, clock_out}, {exp_setup, exp_clock})
      host.sel(1'b0);
      for (int i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         access(8'h10, 8, {8'h00, v[7:0]});
         exp_setup = v[7:0];
         access(8'h20, 8, {8'h00, v[15:8]});
         exp_clock = v[15:8];
         `CHK({setup_out, clock_out}, {exp_setup, exp_clock})
         access(8'h18, 8, 16'h0000);
         `CHK(rd[7:0], exp_setup)
         access(8'h28, 8, 16'h0000);
         `CHK(rd[7:0], exp_clock)
         access(8'h08, 8, 16'h0000);
         `CHK(rd[7:0], 8'h08)
      end
      // Partial word dropped when chip select rises
      host.xfer(4, 16'h0005, 0, rd);
      host.sel(1'b1);
      host.sel(1'b0);
      access(8'h10, 8, 16'h00a5);
      `CHK(setup_out, 8'ha5)
      v = 16'($random(seed));
      push(v);
      wait_ready();
      `CHK({result_ready_n_out, update_busy_out}, 2'h0)
      read_data();
      // Second update while the first is unread
      v = 16'($random(seed));
      w = 16'($random(seed));
      push(v);
      wait_ready();
      push(w);
      k = 0;
      bad = 0;
      repeat (4) if (update_busy_out !== 1'b1) @(negedge clk_in);
      while (update_busy_out === 1'b1 && k < 1000) begin
         if (result_ready_n_out !== 1'b1) bad = 1;
         @(negedge clk_in);
         k++;
      end
      `CHK(k, 500)
      `CHK(bad, 0)
      repeat (3) @(negedge clk_in);
      `CHK(result_ready_n_out, 1'b0)
      read_data();
      @(negedge clk_in);
      cal_done_in = 1'b1;
      @(negedge clk_in);
      cal_done_in = 1'b0;
      wait_ready();
      `CHK(result_ready_n_out, 1'b0)
      access(8'h10, 8, 16'h003c);
      do_reset();
      `CHK({setup_out, result_ready_n_out}, {exp_setup, 1'b1})
      access(8'h20, 8, 16'h0077);
      `CHK(clock_out, 8'h77)
      stop_test();
   end
endmodule

// [verification/adrs_host.sv]
/*
 Host serial port model: drives serial clock, chip select and data in, reads data out.
 Assumes the bench calls its tasks and that clk_in is the master clock.
*/
`timescale 1ns/1ps
module adrs_host (
   input wire logic clk_in,
   input wire logic dout_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out
);
   // ***************
   // Serial framing
   // ***************
   // Serial clock parks high outside frames; it never free-runs here
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b1;
   end

   task automatic sel(input logic lvl);
      @(negedge clk_in);
      cs_n_out = lvl;
      din_out = ~din_out;
      repeat (4) @(negedge clk_in);
   endtask

   // Phases of 6 clocks cover the 2-3 cycle pin synchroniser; gap makes bursts
   task automatic xfer(input int n, input logic [15:0] w, input int gap,
                       output logic [15:0] r);
      r = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk_in);
         sclk_out = 1'b0;
         din_out = w[i];
         repeat (6) @(negedge clk_in);
         r = {r[14:0], dout_in};
         sclk_out = 1'b1;
         repeat (6 + gap) @(negedge clk_in);
      end
      // Hold time over: stop showing the last bit
      din_out = ~din_out;
   endtask
endmodule
